/* File: design/scp_pkg.sv */
// package for the serial configuration port
package scp_pkg;
    localparam int WORD_BITS = 24;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int CNT_BITS = 5;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] ADDR_GAIN_RESET = 8'h03;
    localparam logic [7:0] ADDR_POWER_DOWN = 8'h0f;
    localparam logic [7:0] ADDR_GAIN_LOW = 8'h16;
    localparam logic [7:0] ADDR_GAIN_MID = 8'h17;
    localparam logic [7:0] ADDR_GAIN_HIGH = 8'h18;
    localparam int SOFT_RESET_BIT = 0;
    localparam int GAIN_RESET_BIT = 5;
    localparam int PARTIAL_SLEEP_BIT = 8;
    localparam int FULL_SLEEP_BIT = 9;
    localparam int CHANNELS = 8;
    localparam int GAIN_BITS = 40;
    localparam int GAIN_CNT_BITS = 6;
    localparam logic [15:0] GAIN_LOW_RESET = 16'h0003;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int CLK_MHZ = 200;
    localparam int SCLK_MIN_HALF_NS = 25;
    // host half period rounded up, whole cycles
    localparam int SCLK_HALF_CYC =
        (SCLK_MIN_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] HALF_CYC = 8'(SCLK_HALF_CYC);
    // internal gain link: clock toggles once per this many system cycles, one bit per two toggles
    localparam logic [3:0] GAIN_DIV = 4'h4;
    localparam int SETUP_NS = 8;
    localparam logic [7:0] SETUP_CYC =
        8'((SETUP_NS * CLK_MHZ + 999) / 1000);
    typedef enum logic [1:0] {SCP_IDLE, SCP_SETUP, SCP_LOW, SCP_HIGH}
        scp_host_state_t;
endpackage : scp_pkg

/* File: design/scp_link_if.sv */
// three wire link plus reset and enable pins between host and device
`timescale 1ns/1ps
interface scp_link_if;
    logic select_n;
    logic sclk;
    logic serial_in;
    logic hardware_reset_pin_n;
    logic switch_matrix_enable_pin;
    modport host_mp (
        output select_n,
        output sclk,
        output serial_in,
        output hardware_reset_pin_n,
        output switch_matrix_enable_pin
    );
    modport device_mp (
        input select_n,
        input sclk,
        input serial_in,
        input hardware_reset_pin_n,
        input switch_matrix_enable_pin
    );
endinterface : scp_link_if

/* File: design/scp_gain_link.sv */
// serialiser of the 40 gain-control bits to the internal gain stage
`timescale 1ns/1ps
module scp_gain_link import scp_pkg::*; #(
    parameter int NBITS = GAIN_BITS
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic [NBITS-1:0] word_in,
    output logic gain_link_clock_out,
    output logic gain_link_data_out,
    output logic busy_out
);
    typedef struct packed {
        logic [NBITS-1:0] shreg;
        logic [GAIN_CNT_BITS-1:0] left;
        logic [3:0] div;
        logic sck;
        logic dat;
    } scp_gl_t;
    scp_gl_t st, next_st;

    always_comb begin
        next_st = st;
        if (start_in) begin
            // a fresh write restarts the stream with the newest bits
            next_st.shreg = word_in;
            next_st.left = GAIN_CNT_BITS'(NBITS);
            next_st.div = '0;
            next_st.sck = 1'b0;
            next_st.dat = word_in[0];
        end else if (st.left != '0) begin
            next_st.div = st.div + 4'h1;
            if (st.div == GAIN_DIV - 4'h1) begin
                next_st.div = '0;
                next_st.sck = ~st.sck;
                if (st.sck) begin
                    // bit 0 first, ascending order
                    next_st.shreg = st.shreg >> 1;
                    next_st.left = st.left - 1'b1;
                    next_st.dat = st.shreg[1];
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign gain_link_clock_out = st.sck;
    assign gain_link_data_out = st.dat;
    assign busy_out = (st.left != '0);
endmodule : scp_gain_link

/* File: design/scp_device.sv */
// device end: serial config receiver, register file and gain link
// Summary of operation
// - shift only while select low
// - sample data on serial clock rising edge
// - commit word on every 24th edge
// - discard incomplete trailing bits
// - several words per select period
// - eight address bits then sixteen data
// - work from 20MHz down to hertz
// - host resets registers after power-up; scp_host drives the reset pin only from pin_reset_in
// - reset pin pulse restores defaults
// - soft reset bit restores, self-clears
// - reset pin high during soft reset
// - gain link only for 16-18 with enable
// - eight channel power-down bits
// - partial sleep bit in register 0f
// - separate full sleep bit
// - host writes zero to unused bits
// - host writes shared register at once
`timescale 1ns/1ps
module scp_device import scp_pkg::*; (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    scp_link_if.device_mp link,
    output logic [CHANNELS-1:0] channel_power_down_out,
    output logic partial_sleep_out,
    output logic full_sleep_out,
    output logic gain_stage_reset_bit_out,
    output logic [GAIN_BITS-1:0] gain_word_out,
    output logic gain_link_clock_out,
    output logic gain_link_data_out,
    output logic gain_link_busy_out,
    output logic word_strobe_out,
    output logic [ADDR_BITS-1:0] word_addr_out
);
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] ck_s;
        logic [1:0] di_s;
        logic [1:0] rst_s;
        logic [1:0] en_s;
        logic ck_d;
        logic [WORD_BITS-1:0] shreg;
        logic [CNT_BITS-1:0] cnt;
        logic [DATA_BITS-1:0] pdn_reg;
        logic [DATA_BITS-1:0] gres_reg;
        logic [DATA_BITS-1:0] g_low;
        logic [DATA_BITS-1:0] g_mid;
        logic [DATA_BITS-1:0] g_high;
        logic gstart;
        logic strobe;
        logic [ADDR_BITS-1:0] waddr;
    } scp_dev_t;
    scp_dev_t st, next_st;
    logic [WORD_BITS-1:0] word;
    logic ck_rise;
    logic gl_busy;

    // every pin passes two flops; the second stage is read, plus a third flop on sclk for the rise detect
    assign ck_rise = st.ck_s[1] & ~st.ck_d;

    always_comb begin
        next_st = st;
        word = '0;
        next_st.cs_s = {st.cs_s[0], link.select_n};
        next_st.ck_s = {st.ck_s[0], link.sclk};
        next_st.di_s = {st.di_s[0], link.serial_in};
        next_st.rst_s = {st.rst_s[0], link.hardware_reset_pin_n};
        next_st.en_s = {st.en_s[0], link.switch_matrix_enable_pin};
        next_st.ck_d = st.ck_s[1];
        next_st.gstart = 1'b0;
        next_st.strobe = 1'b0;
        if (st.cs_s[1]) begin
            // select high: clock ignored, partial word dropped
            next_st.cnt = '0;
        end else if (ck_rise) begin
            word = {st.shreg[WORD_BITS-2:0], st.di_s[1]};
            next_st.shreg = word;
            if (st.cnt == LAST_BIT) begin
                next_st.cnt = '0;
                next_st.strobe = 1'b1;
                // address first on the wire, so it lands on top
                next_st.waddr = word[WORD_BITS-1 -: ADDR_BITS];
                case (word[WORD_BITS-1 -: ADDR_BITS])
                    ADDR_GAIN_RESET: next_st.gres_reg = word[15:0];
                    ADDR_POWER_DOWN: next_st.pdn_reg = word[15:0];
                    ADDR_GAIN_LOW: next_st.g_low = word[15:0];
                    ADDR_GAIN_MID: next_st.g_mid = word[15:0];
                    ADDR_GAIN_HIGH: next_st.g_high = word[15:0];
                    default: ;
                endcase
                if ((word[WORD_BITS-1 -: ADDR_BITS] == ADDR_GAIN_LOW ||
                     word[WORD_BITS-1 -: ADDR_BITS] == ADDR_GAIN_MID ||
                     word[WORD_BITS-1 -: ADDR_BITS] == ADDR_GAIN_HIGH)
                    && st.en_s[1]) begin
                    next_st.gstart = 1'b1;
                end
                // soft reset is not stored, so it reads as cleared
                if (word[WORD_BITS-1 -: ADDR_BITS] == ADDR_SOFT_RESET &&
                    word[SOFT_RESET_BIT]) begin
                    next_st.pdn_reg = REG_RESET;
                    next_st.gres_reg = REG_RESET;
                    next_st.g_low = GAIN_LOW_RESET;
                    next_st.g_mid = REG_RESET;
                    next_st.g_high = REG_RESET;
                end
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
        // low pulse on the reset pin: registers back to defaults
        if (!st.rst_s[1]) begin
            next_st.pdn_reg = REG_RESET;
            next_st.gres_reg = REG_RESET;
            next_st.g_low = GAIN_LOW_RESET;
            next_st.g_mid = REG_RESET;
            next_st.g_high = REG_RESET;
            next_st.cnt = '0;
            next_st.gstart = 1'b0;
            next_st.strobe = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.cs_s <= 2'h3;
            st.rst_s <= 2'h3;
            st.g_low <= GAIN_LOW_RESET;
        end else begin
            st <= next_st;
        end
    end

    scp_gain_link #(.NBITS(GAIN_BITS)) u_gain_link (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .start_in(st.gstart),
        .word_in({st.g_high[7:0], st.g_mid, st.g_low}),
        .gain_link_clock_out(gain_link_clock_out),
        .gain_link_data_out(gain_link_data_out),
        .busy_out(gl_busy)
    );

    assign channel_power_down_out = st.pdn_reg[CHANNELS-1:0];
    assign partial_sleep_out = st.pdn_reg[PARTIAL_SLEEP_BIT];
    assign full_sleep_out = st.pdn_reg[FULL_SLEEP_BIT];
    assign gain_stage_reset_bit_out = st.gres_reg[GAIN_RESET_BIT];
    assign gain_word_out = {st.g_high[7:0], st.g_mid, st.g_low};
    assign gain_link_busy_out = gl_busy;
    assign word_strobe_out = st.strobe;
    assign word_addr_out = st.waddr;
endmodule : scp_device

/* File: design/scp_host.sv */
// host end: sends 24-bit writes, drives reset and enable pins
`timescale 1ns/1ps
module scp_host import scp_pkg::*; (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire logic [ADDR_BITS-1:0] req_addr_in,
    input wire logic [DATA_BITS-1:0] req_data_in,
    input wire logic hold_select_in,
    input wire logic pin_reset_in,
    input wire logic switch_enable_in,
    output logic req_ready_out,
    output logic done_out,
    scp_link_if.host_mp link
);
    typedef struct packed {
        scp_host_state_t fsm;
        logic [WORD_BITS-1:0] shreg;
        logic [CNT_BITS-1:0] cnt;
        logic [7:0] tmr;
        logic cs_n;
        logic sck;
        logic dout;
        logic done;
        logic rst_n;
        logic en;
    } scp_host_st_t;
    scp_host_st_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.rst_n = ~pin_reset_in;
        next_st.en = switch_enable_in;
        case (st.fsm)
            SCP_IDLE: begin
                if (req_valid_in) begin
                    // unused bits are the caller's to zero
                    next_st.shreg = {req_addr_in, req_data_in};
                    next_st.cnt = '0;
                    next_st.sck = 1'b0;
                    next_st.dout = req_addr_in[ADDR_BITS-1];
                    next_st.tmr = '0;
                    next_st.fsm = st.cs_n ? SCP_SETUP : SCP_LOW;
                    next_st.cs_n = 1'b0;
                end else if (!hold_select_in) begin
                    next_st.cs_n = 1'b1;
                end
            end
            SCP_SETUP: begin
                next_st.tmr = st.tmr + 8'h1;
                if (st.tmr == SETUP_CYC) begin
                    next_st.tmr = '0;
                    next_st.fsm = SCP_LOW;
                end
            end
            SCP_LOW: begin
                next_st.tmr = st.tmr + 8'h1;
                if (st.tmr == HALF_CYC - 8'h1) begin
                    next_st.tmr = '0;
                    next_st.sck = 1'b1; // data stable across rise
                    next_st.fsm = SCP_HIGH;
                end
            end
            SCP_HIGH: begin
                next_st.tmr = st.tmr + 8'h1;
                if (st.tmr == HALF_CYC - 8'h1) begin
                    next_st.tmr = '0;
                    next_st.sck = 1'b0;
                    next_st.shreg = st.shreg << 1;
                    next_st.dout = st.shreg[WORD_BITS-2];
                    if (st.cnt == LAST_BIT) begin
                        next_st.done = 1'b1;
                        next_st.fsm = SCP_IDLE;
                    end else begin
                        next_st.cnt = st.cnt + 1'b1;
                        next_st.fsm = SCP_LOW;
                    end
                end
            end
            default: next_st.fsm = SCP_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.fsm <= SCP_IDLE;
            st.cs_n <= 1'b1;
            st.rst_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign req_ready_out = (st.fsm == SCP_IDLE);
    assign done_out = st.done;
    assign link.select_n = st.cs_n;
    assign link.sclk = st.sck;
    assign link.serial_in = st.dout;
    assign link.hardware_reset_pin_n = st.rst_n;
    assign link.switch_matrix_enable_pin = st.en;
endmodule : scp_host

/* File: sim/scp_link_assertions.sv */
// wire checks on the host to device configuration link
`timescale 1ns/1ps
module scp_link_assertions (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic hardware_reset_pin_n,
    input wire logic switch_matrix_enable_pin
);
    logic [4:0] bits_q;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // rises within the current word, cleared while deselected
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bits_q <= 5'h00;
        end else if (select_n) begin
            bits_q <= 5'h00;
        end else if ($rose(sclk)) begin
            bits_q <= (bits_q == 5'h17) ? 5'h00 : bits_q + 5'h01;
        end
    end
    sequence s_high_phase;
        sclk [*5] ##1 !sclk;
    endsequence
    sequence s_low_phase;
        !sclk [*5];
    endsequence
    a_high_time: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase wrong");
    a_low_time: assert property ($fell(sclk) |-> s_low_phase)
        else $error("serial clock low phase too short");
    a_select_setup: assert property ($fell(select_n) |-> !sclk [*2])
        else $error("clock rose too soon after select");
    a_rise_in_frame: assert property ($rose(sclk) |->
        !select_n && !$past(select_n, 2))
        else $error("clock rise outside a frame");
    a_data_stable: assert property ($rose(sclk) |->
        $stable(serial_in) [*5])
        else $error("data moved around clock rise");
    a_data_moves_low: assert property ($changed(serial_in) |-> !sclk)
        else $error("data changed with clock high");
    a_idle_clock_low: assert property (select_n |-> !sclk)
        else $error("clock high while deselected");
    a_whole_words: assert property ($rose(select_n) |-> bits_q == 5'h00)
        else $error("frame ended inside a word");
endmodule : scp_link_assertions

/* File: sim/serial_config_port_tb_top.sv */
// self-checking bench for both ends of the configuration link
`timescale 1ns/1ps
module serial_config_port_tb_top
    import scp_pkg::*;
;
    localparam logic [71:0] DEF = {56'h0, GAIN_LOW_RESET};
    localparam logic [7:0] ATAB [7] = '{8'h00, 8'h03, 8'h0f, 8'h16,
        8'h17, 8'h18, 8'h42};
    localparam logic [15:0] MTAB [7] = '{16'h0000, 16'h0020, 16'h03ff,
        16'hfffc, 16'hffff, 16'h00ff, 16'hffff};
    logic mclk_in = 1'b0, arst_n_in = 1'b0;
    logic vld = 1'b0, hold = 1'b0, prst = 1'b0, sw_en = 1'b0;
    logic [7:0] addr = 8'h00, waddr, last_addr, pd, pd_b;
    logic [15:0] data = 16'h0000;
    logic rdy, done, part, full, grst, gclk, gdat, gbusy, stb, stb_b, gclk_q;
    logic [39:0] gword, cap;
    logic [71:0] sa;
    int err_count = 0, checks = 0, n_str = 0, n_str_b = 0, cap_n = 0;
    integer seed = 32'h8dd6210b;
    scp_link_if link_a();
    scp_link_if link_b();
    always #2.5 mclk_in = ~mclk_in;
    scp_host i_scp_host (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .req_valid_in(vld), .req_addr_in(addr), .req_data_in(data),
        .hold_select_in(hold), .pin_reset_in(prst), .switch_enable_in(sw_en),
        .req_ready_out(rdy), .done_out(done), .link(link_a.host_mp));
    scp_device i_scp_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .link(link_a.device_mp), .channel_power_down_out(pd),
        .partial_sleep_out(part), .full_sleep_out(full),
        .gain_stage_reset_bit_out(grst), .gain_word_out(gword),
        .gain_link_clock_out(gclk), .gain_link_data_out(gdat),
        .gain_link_busy_out(gbusy), .word_strobe_out(stb),
        .word_addr_out(waddr));
    // second device faces the bench, which can break frames on purpose
    scp_device i_scp_device_raw (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .link(link_b.device_mp), .channel_power_down_out(pd_b),
        .partial_sleep_out(), .full_sleep_out(), .gain_stage_reset_bit_out(),
        .gain_word_out(), .gain_link_clock_out(), .gain_link_data_out(),
        .gain_link_busy_out(), .word_strobe_out(stb_b), .word_addr_out());
    scp_link_assertions i_scp_link_assertions (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .select_n(link_a.select_n),
        .sclk(link_a.sclk), .serial_in(link_a.serial_in),
        .hardware_reset_pin_n(link_a.hardware_reset_pin_n),
        .switch_matrix_enable_pin(link_a.switch_matrix_enable_pin));
    always @(posedge mclk_in) begin
        gclk_q <= gclk;
        n_str <= n_str + int'(stb === 1'b1);
        n_str_b <= n_str_b + int'(stb_b === 1'b1);
        if (stb === 1'b1) last_addr <= waddr;
        if (gclk === 1'b1 && gclk_q === 1'b0) cap <= {gdat, cap[39:1]};
        cap_n <= cap_n + int'(gclk === 1'b1 && gclk_q === 1'b0);
    end
    function automatic logic [71:0] model(logic [71:0] s, logic [7:0] a,
        logic [15:0] d);
        case (a)
            8'h00: s = d[0] ? DEF : s;
            8'h03: s[55:40] = d;
            8'h0f: s[71:56] = d;
            8'h16: s[15:0] = d;
            8'h17: s[31:16] = d;
            8'h18: s[39:32] = d[7:0];
            default: s = s;
        endcase
        return s;
    endfunction : model
    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk_a();
        chk("power_down", pd, sa[63:56]);
        chk("partial_sleep", part, sa[64]);
        chk("full_sleep", full, sa[65]);
        chk("gain_reset", grst, sa[45]);
        chk("gain_word", gword, sa[39:0]);
    endtask : chk_a
    task automatic do_write(logic [7:0] a, logic [15:0] d, logic h);
        int n;
        int n0;
        int s0;
        n0 = cap_n;
        s0 = n_str;
        @(negedge mclk_in);
        vld = 1'b1;
        addr = a;
        data = d;
        hold = h;
        for (n = 0; rdy !== 1'b1 && n < 600; n++) @(negedge mclk_in);
        @(negedge mclk_in);
        vld = 1'b0;
        for (; done !== 1'b1 && n < 600; n++) @(negedge mclk_in);
        // stream may outlast the host frame, so wait it out
        for (; gbusy !== 1'b0 && n < 1200; n++) @(negedge mclk_in);
        sa = model(sa, a, d);
        chk("wait", n < 1200, 1);
        chk("strobes", n_str - s0, 1);
        chk("word_addr", last_addr, a);
        chk_a();
        if (sw_en && a inside {8'h16, 8'h17, 8'h18}) begin
            chk("gain_stream", cap, sa[39:0]);
            chk("gain_bits", cap_n - n0, 40);
        end else begin
            chk("gain_bits", cap_n - n0, 0);
        end
    endtask : do_write
    task automatic raw_case(logic [47:0] bits, int nb, logic sel, int ns,
        logic [7:0] pd_exp);
        int s0;
        s0 = n_str_b;
        @(negedge mclk_in);
        link_b.select_n = ~sel;
        repeat (8) @(negedge mclk_in);
        for (int i = nb - 1; i >= 0; i--) begin
            link_b.serial_in = bits[i];
            repeat (12) @(negedge mclk_in);
            // short high phase gives an uneven duty cycle
            link_b.sclk = 1'b1;
            repeat (4) @(negedge mclk_in);
            link_b.sclk = 1'b0;
        end
        repeat (8) @(negedge mclk_in);
        link_b.select_n = 1'b1;
        link_b.serial_in = ~link_b.serial_in;
        repeat (8) @(negedge mclk_in);
        chk("strobes_b", n_str_b - s0, ns);
        chk("power_down_b", pd_b, pd_exp);
    endtask : raw_case
    initial begin
        link_b.select_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.serial_in = 1'b0;
        link_b.hardware_reset_pin_n = 1'b1;
        link_b.switch_matrix_enable_pin = 1'b0;
        sa = DEF;
        repeat (16) @(negedge mclk_in);
        arst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk_a();
        $display("test reset_defaults done");
        for (int i = 0; i < 14; i++) begin
            sw_en = 1'($random(seed));
            do_write(ATAB[i % 7], (16'($random(seed)) & MTAB[i % 7]) |
                ((i % 7 == 3) ? 16'h0003 : 16'h0000),
                i < 13 && 1'($random(seed)));
        end
        $display("test random_writes done");
        sw_en = 1'b1;
        do_write(8'h0f, 16'h03ff, 1'b1);
        do_write(8'h16, 16'h5a5b, 1'b1);
        do_write(8'h00, 16'h0001, 1'b0);
        do_write(8'h0f, 16'h0155, 1'b0);
        $display("test soft_reset done");
        prst = 1'b1;
        repeat (2) @(negedge mclk_in);
        prst = 1'b0;
        repeat (10) @(negedge mclk_in);
        sa = DEF;
        chk_a();
        $display("test pin_reset done");
        raw_case({24'h0, 8'h0f, 16'h00a5}, 24, 1'b1, 1, 8'ha5);
        raw_case({24'h0, 8'h0f, 16'h005a}, 24, 1'b0, 0, 8'ha5);
        raw_case({18'h0, 8'h0f, 16'h003c, 6'h2a}, 30, 1'b1, 1, 8'h3c);
        raw_case({38'h0, 8'h0f, 2'h3}, 10, 1'b1, 0, 8'h3c);
        raw_case({24'h0, 8'h0f, 16'h0081}, 24, 1'b1, 1, 8'h81);
        raw_case({8'h0f, 16'h00c3, 8'h0f, 16'h0018}, 48, 1'b1, 2, 8'h18);
        raw_case({24'h0, 8'h00, 16'h0001}, 24, 1'b1, 1, 8'h00);
        raw_case({24'h0, 8'h0f, 16'h00ff}, 24, 1'b1, 1, 8'hff);
        link_b.hardware_reset_pin_n = 1'b0;
        repeat (4) @(negedge mclk_in);
        link_b.hardware_reset_pin_n = 1'b1;
        repeat (8) @(negedge mclk_in);
        chk("power_down_b", pd_b, 8'h00);
        $display("test raw_link done");
        test_done();
    end
    initial begin
        #400000;
        err_count++;
        test_done();
    end
endmodule : serial_config_port_tb_top
